//--- rtl/touch_adc_pkg.sv
package touch_adc_pkg;

  // ----------------------------------------------------------------
  // converter and frame sizes
  // ----------------------------------------------------------------
  localparam int RES_BITS   = 12;
  localparam int CMD_BITS   = 8;
  localparam int SETUP_BITS = 4;

  // ----------------------------------------------------------------
  // serial edge positions, counted from the start bit
  // ----------------------------------------------------------------
  localparam logic [4:0] CHAN_KNOWN_RISE  = 5'h04;
  localparam logic [4:0] CMD_LAST_RISE    = 5'h08;
  localparam logic [4:0] SETUP_LAST_RISE  = 5'h0c;
  localparam logic [4:0] TRACK_FIRST_FALL = 5'h05;
  localparam logic [4:0] TRACK_LAST_FALL  = 5'h08;
  localparam logic [4:0] CONV_LAST_FALL   = 5'h14;

  // ----------------------------------------------------------------
  // channel codes and setup fields
  // ----------------------------------------------------------------
  localparam logic [2:0] CH_TEMP0 = 3'h0;
  localparam logic [2:0] CH_Y     = 3'h1;
  localparam logic [2:0] CH_SETUP = 3'h2;
  localparam logic [2:0] CH_Z1    = 3'h3;
  localparam logic [2:0] CH_Z2    = 3'h4;
  localparam logic [2:0] CH_X     = 3'h5;
  localparam logic [2:0] CH_AUX   = 3'h6;
  localparam logic [2:0] CH_TEMP1 = 3'h7;

  localparam logic [2:0] SETUP_ADDR_FUNC1 = 3'h0;
  localparam int         CLKSEL_POS       = 0;
  localparam logic [3:0] SETUP_RESET      = 4'h0;

  // ----------------------------------------------------------------
  // result codes and timing
  // ----------------------------------------------------------------
  localparam logic [11:0] RESULT_RESET = 12'h000;
  localparam logic [11:0] SAR_MSB      = 12'h800;
  localparam int CLK_PERIOD_NS = 10;
  localparam int OSC_PERIOD_NS = 278;
  localparam int OSC_CYCLES    = OSC_PERIOD_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // analog routing
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    POS_NONE  = 3'h0,
    POS_TEMP0 = 3'h1,
    POS_TEMP1 = 3'h2,
    POS_XP    = 3'h3,
    POS_YP    = 3'h4,
    POS_YN    = 3'h5,
    POS_IN    = 3'h6,
    POS_PROBE = 3'h7
  } ain_pos_type;

  typedef enum logic [1:0] {
    NEG_VSS = 2'h0,
    NEG_YN  = 2'h1,
    NEG_XN  = 2'h2,
    NEG_BL  = 2'h3
  } ain_neg_type;

  typedef struct packed {
    ain_pos_type pos;
    ain_neg_type neg;
    logic        differential;
    logic        x_drive;
    logic        y_drive;
    logic        pressure_drive;
    logic        top_left_corner_vdd;
    logic        top_right_corner_on;
    logic        bottom_left_corner_on;
    logic        bottom_right_corner_vdd;
  } analog_ctrl_type;

  localparam analog_ctrl_type ANALOG_IDLE = '{POS_NONE, NEG_VSS, 1'b0, 1'b0, 1'b0,
                                              1'b0, 1'b0, 1'b0, 1'b0, 1'b0};

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_CMD   = 5'b00010,
    ST_SETUP = 5'b00100,
    ST_CONV  = 5'b01000,
    ST_DONE  = 5'b10000
  } state_type;

endpackage : touch_adc_pkg

//--- rtl/sar_register.sv
`timescale 1ns/1ps
`default_nettype none
module sar_register (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // control
  input  wire logic        start_i,
  input  wire logic        step_i,
  input  wire logic        comp_i,
  // results
  output logic [11:0]      trial_o,
  output logic [11:0]      result_o,
  output logic             done_o
);

  logic [11:0] mask;
  logic [11:0] next_mask;
  logic [11:0] next_trial;
  logic [11:0] next_result;
  logic        next_done;
  logic [11:0] kept;

  // ----------------------------------------------------------------
  // successive approximation
  // ----------------------------------------------------------------
  always_comb begin
    next_mask   = mask;
    next_trial  = trial_o;
    next_result = result_o;
    next_done   = 1'b0;
    kept        = comp_i ? trial_o : (trial_o & ~mask);
    if (start_i) begin
      next_mask  = touch_adc_pkg::SAR_MSB;
      next_trial = touch_adc_pkg::SAR_MSB;
    end else if (step_i && (mask != 12'h000)) begin
      // straight binary: a set bit survives while input stays at or above trial
      next_mask  = mask >> 1;
      next_trial = kept | (mask >> 1);
      if (mask == 12'h001) begin
        next_result = kept;
        next_done   = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mask     <= 12'h000;
      trial_o  <= touch_adc_pkg::RESULT_RESET;
      result_o <= touch_adc_pkg::RESULT_RESET;
      done_o   <= 1'b0;
    end else begin
      mask     <= next_mask;
      trial_o  <= next_trial;
      result_o <= next_result;
      done_o   <= next_done;
    end
  end

endmodule : sar_register
`default_nettype wire

//--- rtl/touch_panel_adc_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module touch_panel_adc_sequencer (
  // clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  // serial pins
  input  wire logic                          sclk_i,
  input  wire logic                          chip_select_low_i,
  input  wire logic                          din_i,
  output logic                               dout_o,
  output logic                               dout_oe_o,
  // analog front end
  input  wire logic                          comp_i,
  input  wire logic                          panel_five_wire_i,
  output logic [11:0]                        trial_code_o,
  output logic                               track_o,
  output touch_adc_pkg::analog_ctrl_type     analog_o,
  // status
  output logic [11:0]                        result_o,
  output logic                               result_valid_o,
  output logic [3:0]                         setup_field_o,
  output logic                               internal_clock_o
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] sclk_sync;
  logic [1:0] cs_sync;
  logic [1:0] din_sync;
  logic       sclk_rise, sclk_fall, selected, din_s;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sclk_sync <= 3'h0;
      cs_sync   <= 2'h3;
      din_sync  <= 2'h0;
    end else begin
      sclk_sync <= {sclk_sync[1:0], sclk_i};
      cs_sync   <= {cs_sync[0], chip_select_low_i};
      din_sync  <= {din_sync[0], din_i};
    end
  end

  // edge detection only looks at the second and third stages
  assign sclk_rise = sclk_sync[1] & ~sclk_sync[2];
  assign sclk_fall = ~sclk_sync[1] & sclk_sync[2];
  assign selected  = ~cs_sync[1];
  assign din_s     = din_sync[1];

  // ----------------------------------------------------------------
  // channel routing
  // ----------------------------------------------------------------
  function automatic touch_adc_pkg::analog_ctrl_type route(input logic [2:0] ch, input logic five);
    touch_adc_pkg::analog_ctrl_type r;
    r = touch_adc_pkg::ANALOG_IDLE;
    unique case (ch)
      touch_adc_pkg::CH_TEMP0: r.pos = touch_adc_pkg::POS_TEMP0;
      touch_adc_pkg::CH_TEMP1: r.pos = touch_adc_pkg::POS_TEMP1;
      touch_adc_pkg::CH_AUX:   r.pos = five ? touch_adc_pkg::POS_NONE : touch_adc_pkg::POS_IN;
      touch_adc_pkg::CH_SETUP: r.pos = touch_adc_pkg::POS_NONE;
      touch_adc_pkg::CH_Y: begin
        r.differential = 1'b1;
        if (five) begin
          r.pos                   = touch_adc_pkg::POS_PROBE;
          r.neg                   = touch_adc_pkg::NEG_BL;
          r.top_left_corner_vdd   = 1'b1;
          r.top_right_corner_on   = 1'b1;
          r.bottom_left_corner_on = 1'b1;
        end else begin
          r.pos     = touch_adc_pkg::POS_XP;
          r.neg     = touch_adc_pkg::NEG_YN;
          r.y_drive = 1'b1;
        end
      end
      touch_adc_pkg::CH_X: begin
        r.differential = 1'b1;
        if (five) begin
          r.pos                     = touch_adc_pkg::POS_PROBE;
          r.neg                     = touch_adc_pkg::NEG_BL;
          r.top_right_corner_on     = 1'b1;
          r.bottom_left_corner_on   = 1'b1;
          r.bottom_right_corner_vdd = 1'b1;
        end else begin
          r.pos     = touch_adc_pkg::POS_YP;
          r.neg     = touch_adc_pkg::NEG_XN;
          r.x_drive = 1'b1;
        end
      end
      touch_adc_pkg::CH_Z1, touch_adc_pkg::CH_Z2: begin
        // pressure is reserved on five-wire panels, so nothing is driven there
        if (!five) begin
          r.differential   = 1'b1;
          r.pressure_drive = 1'b1;
          r.neg            = touch_adc_pkg::NEG_XN;
          r.pos            = (ch == touch_adc_pkg::CH_Z1) ? touch_adc_pkg::POS_XP : touch_adc_pkg::POS_YN;
        end
      end
    endcase
    return r;
  endfunction : route

  // ----------------------------------------------------------------
  // sequencer state
  // ----------------------------------------------------------------
  touch_adc_pkg::state_type state, next_state;
  logic [4:0]  rise_cnt, next_rise_cnt;
  logic [4:0]  fall_cnt, next_fall_cnt;
  logic [7:0]  cmd, next_cmd;
  logic [2:0]  channel, next_channel;
  logic        routed, next_routed;
  logic [3:0]  setup_shift, next_setup_shift;
  logic [3:0]  next_setup_field;
  logic        next_internal_clock;
  logic        next_track, next_dout, next_dout_oe;
  touch_adc_pkg::analog_ctrl_type next_analog;
  logic        sar_start, sar_step, osc_tick;
  logic [4:0]  osc_cnt, next_osc_cnt;
  logic [4:0]  nr, nf, bit_idx;

  assign osc_tick = (osc_cnt == 5'(touch_adc_pkg::OSC_CYCLES - 1));

  always_comb begin
    next_state          = state;
    next_rise_cnt       = rise_cnt;
    next_fall_cnt       = fall_cnt;
    next_cmd            = cmd;
    next_channel        = channel;
    next_routed         = routed;
    next_setup_shift    = setup_shift;
    next_setup_field    = setup_field_o;
    next_internal_clock = internal_clock_o;
    next_track          = track_o;
    next_dout           = dout_o;
    next_osc_cnt        = osc_tick ? 5'h00 : osc_cnt + 5'h01;
    sar_start           = 1'b0;
    nr                  = rise_cnt + 5'h01;
    nf                  = fall_cnt + 5'h01;
    bit_idx             = touch_adc_pkg::CONV_LAST_FALL - nf;
    next_dout_oe        = selected;
    sar_step            = internal_clock_o ? osc_tick : (sclk_fall && state == touch_adc_pkg::ST_CONV);
    if (!selected) begin
      next_state    = touch_adc_pkg::ST_IDLE;
      next_rise_cnt = 5'h00;
      next_fall_cnt = 5'h00;
      next_track    = 1'b0;
      next_routed   = 1'b0;
      next_dout     = 1'b0;
    end else begin
      unique case (state)
        touch_adc_pkg::ST_IDLE: begin
          // first high bit starts a frame
          if (sclk_rise && din_s) begin
            next_state    = touch_adc_pkg::ST_CMD;
            next_rise_cnt = 5'h01;
            next_fall_cnt = 5'h00;
            next_cmd      = {7'h00, din_s};
          end
        end
        touch_adc_pkg::ST_CMD: begin
          if (sclk_rise) begin
            next_rise_cnt = nr;
            next_cmd      = {cmd[6:0], din_s};
            if (nr == touch_adc_pkg::CHAN_KNOWN_RISE) begin
              next_channel = {cmd[1:0], din_s};
              next_routed  = 1'b1;
            end
          end
          if (sclk_fall) begin
            next_fall_cnt = nf;
            if (nf == touch_adc_pkg::TRACK_FIRST_FALL && channel != touch_adc_pkg::CH_SETUP) begin
              next_track = 1'b1;
            end
            if (nf == touch_adc_pkg::TRACK_LAST_FALL) begin
              next_track = 1'b0;
              if (channel == touch_adc_pkg::CH_SETUP) begin
                next_state = cmd[0] ? touch_adc_pkg::ST_DONE : touch_adc_pkg::ST_SETUP;
              end else begin
                next_state = touch_adc_pkg::ST_CONV;
                sar_start  = 1'b1;
              end
            end
          end
        end
        touch_adc_pkg::ST_SETUP: begin
          if (sclk_rise) begin
            next_rise_cnt    = nr;
            next_setup_shift = {setup_shift[2:0], din_s};
            if (nr == touch_adc_pkg::SETUP_LAST_RISE) begin
              next_state       = touch_adc_pkg::ST_DONE;
              next_setup_field = {setup_shift[2:0], din_s};
              if (cmd[3:1] == touch_adc_pkg::SETUP_ADDR_FUNC1) begin
                next_internal_clock = next_setup_field[touch_adc_pkg::CLKSEL_POS];
              end
            end
          end
        end
        touch_adc_pkg::ST_CONV: begin
          if (sclk_fall) begin
            next_fall_cnt = nf;
            // one result bit per falling edge
            next_dout = internal_clock_o ? result_o[bit_idx[3:0]] : comp_i;
            if (nf == touch_adc_pkg::CONV_LAST_FALL) begin
              next_state = touch_adc_pkg::ST_DONE;
            end
          end
        end
        touch_adc_pkg::ST_DONE: if (sclk_fall) next_dout = 1'b0;
      endcase
    end
    next_analog = routed ? route(channel, panel_five_wire_i) : touch_adc_pkg::ANALOG_IDLE;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state            <= touch_adc_pkg::ST_IDLE;
      rise_cnt         <= 5'h00;
      fall_cnt         <= 5'h00;
      cmd              <= 8'h00;
      channel          <= touch_adc_pkg::CH_TEMP0;
      routed           <= 1'b0;
      setup_shift      <= touch_adc_pkg::SETUP_RESET;
      setup_field_o    <= touch_adc_pkg::SETUP_RESET;
      internal_clock_o <= 1'b0;
      track_o          <= 1'b0;
      dout_o           <= 1'b0;
      dout_oe_o        <= 1'b0;
      osc_cnt          <= 5'h00;
      analog_o         <= touch_adc_pkg::ANALOG_IDLE;
    end else begin
      state            <= next_state;
      rise_cnt         <= next_rise_cnt;
      fall_cnt         <= next_fall_cnt;
      cmd              <= next_cmd;
      channel          <= next_channel;
      routed           <= next_routed;
      setup_shift      <= next_setup_shift;
      setup_field_o    <= next_setup_field;
      internal_clock_o <= next_internal_clock;
      track_o          <= next_track;
      dout_o           <= next_dout;
      dout_oe_o        <= next_dout_oe;
      osc_cnt          <= next_osc_cnt;
      analog_o         <= next_analog;
    end
  end

  // ----------------------------------------------------------------
  // converter register
  // ----------------------------------------------------------------
  // straight binary twelve-bit search
  sar_register u_sar (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .start_i  (sar_start),
    .step_i   (sar_step),
    .comp_i   (comp_i),
    .trial_o  (trial_code_o),
    .result_o (result_o),
    .done_o   (result_valid_o)
  );

endmodule : touch_panel_adc_sequencer
`default_nettype wire

//--- bench/touch_panel_adc_sequencer_props.sv
`timescale 1ns/1ps
`default_nettype none
module touch_panel_adc_sequencer_props (
  // clock and reset
  input wire logic                          clk_i,
  input wire logic                          rst_i,
  // serial pins
  input wire logic                          sclk_i,
  input wire logic                          chip_select_low_i,
  input wire logic                          dout_o,
  input wire logic                          dout_oe_o,
  // converter side
  input wire logic [11:0]                   trial_code_o,
  input wire logic                          track_o,
  input wire touch_adc_pkg::analog_ctrl_type analog_o,
  input wire logic [11:0]                   result_o,
  input wire logic                          result_valid_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ----------------------------------------------------------------
  // deselect releases everything
  // ----------------------------------------------------------------
  // output released
  chk_oe_release: assert property (chip_select_low_i [*5] |-> !dout_oe_o)
    else $error("dout enabled while deselected");
  chk_track_release: assert property (chip_select_low_i [*5] |-> !track_o)
    else $error("tracking while deselected");
  chk_route_idle: assert property (chip_select_low_i [*5] |-> analog_o == touch_adc_pkg::ANALOG_IDLE)
    else $error("routing active while deselected");

  // ----------------------------------------------------------------
  // conversion timing
  // ----------------------------------------------------------------
  // result only with valid
  chk_result_cause: assert property ($changed(result_o) |-> result_valid_o)
    else $error("result changed without valid");
  chk_valid_pulse: assert property (result_valid_o |=> !result_valid_o)
    else $error("valid longer than one cycle");
  // track starts after a falling edge, so sclk is low
  chk_track_edge: assert property ($rose(track_o) |-> !sclk_i && !$past(sclk_i))
    else $error("tracking started off a falling edge");
  // end of tracking starts the search at mid code
  chk_trial_start: assert property ($fell(track_o) && !chip_select_low_i
                                    |-> ##[0:3] trial_code_o == touch_adc_pkg::SAR_MSB)
    else $error("search did not start at mid code");
  // data moves on falling edges only
  chk_dout_edge: assert property (dout_oe_o && $past(dout_oe_o) && $changed(dout_o) |-> !sclk_i)
    else $error("dout changed while sclk high");
  chk_single_ref: assert property (analog_o.pos inside {touch_adc_pkg::POS_TEMP0, touch_adc_pkg::POS_TEMP1,
                                   touch_adc_pkg::POS_IN}
                                   |-> !analog_o.differential && analog_o.neg == touch_adc_pkg::NEG_VSS)
    else $error("single-ended channel not referenced to ground");
endmodule : touch_panel_adc_sequencer_props

bind touch_panel_adc_sequencer touch_panel_adc_sequencer_props PROPS (
  .clk_i, .rst_i, .sclk_i, .chip_select_low_i, .dout_o, .dout_oe_o,
  .trial_code_o, .track_o, .analog_o, .result_o, .result_valid_o
);
`default_nettype wire

//--- bench/serial_host.sv
`timescale 1ns/1ps
`default_nettype none
module serial_host (
  // clock
  input  wire logic clk_i,
  // serial pins
  input  wire logic dout_i,
  input  wire logic dout_oe_i,
  output logic      sclk_o,
  output logic      chip_select_low_o,
  output logic      din_o
);
  int   half;
  logic line;

  // host owns the clock, idle low
  initial begin
    sclk_o = 1'b0;
    chip_select_low_o = 1'b1;
    din_o = 1'b0;
    line = 1'b0;
    // bench may slow the clock to stretch tracking
    half = 8;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick

  // command then optional field, zeros around it
  task automatic frame(input logic [11:0] bits, input int nbits, input int lead, input int nk,
                       output logic [11:0] rx);
    int j;
    chip_select_low_o = 1'b0;
    tick(half);
    for (int k = 1; k <= lead + nk; k++) begin
      j = k - lead;
      din_o = (j >= 1 && j <= nbits) ? bits[12-j] : 1'b0;
      tick(half);
      // released line reads inverted so a stale bit never passes
      if (j >= 10 && j <= 21) begin
        line = dout_oe_i ? dout_i : ~line;
        rx[21-j] = line;
      end
      sclk_o = 1'b1;
      tick(half);
      sclk_o = 1'b0;
    end
    din_o = 1'b0;
  endtask : frame

  task automatic deselect();
    tick(half);
    chip_select_low_o = 1'b1;
    tick(4 * half);
  endtask : deselect
endmodule : serial_host
`default_nettype wire

//--- bench/touch_panel_adc_sequencer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module touch_panel_adc_sequencer_tb_top;
  logic                           clk_i;
  logic                           rst_i;
  logic                           sclk_i;
  logic                           chip_select_low_i;
  logic                           din_i;
  logic                           dout_o;
  logic                           dout_oe_o;
  logic                           comp_i;
  logic                           panel_five_wire_i;
  logic [11:0]                    trial_code_o;
  logic                           track_o;
  touch_adc_pkg::analog_ctrl_type analog_o;
  logic [11:0]                    result_o;
  logic                           result_valid_o;
  logic [3:0]                     setup_field_o;
  logic                           internal_clock_o;
  logic [11:0]                    ain;
  logic [3:0]                     corners;
  logic [15:0]                    lfsr;
  int                             num_errors;
  int                             checks;
  int                             cycles;

  touch_panel_adc_sequencer DUT (
    .clk_i, .rst_i, .sclk_i, .chip_select_low_i, .din_i, .dout_o, .dout_oe_o, .comp_i,
    .panel_five_wire_i, .trial_code_o, .track_o, .analog_o, .result_o, .result_valid_o,
    .setup_field_o, .internal_clock_o
  );
  serial_host HOST (
    .clk_i, .dout_i(dout_o), .dout_oe_i(dout_oe_o), .sclk_o(sclk_i),
    .chip_select_low_o(chip_select_low_i), .din_o(din_i)
  );

  // ideal comparator: the search must land on ain exactly
  assign comp_i = (ain >= trial_code_o);
  assign corners = {analog_o.top_left_corner_vdd, analog_o.top_right_corner_on,
                    analog_o.bottom_left_corner_on, analog_o.bottom_right_corner_vdd};

  initial clk_i = 1'b0;
  always #5 clk_i = ~clk_i;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] lfsr_next();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction : lfsr_next

  // packs {pos, neg, differential}; five-wire unsupported channels route nothing
  function automatic logic [5:0] route(input logic [2:0] ch, input logic f);
    case (ch)
      3'h0: return {touch_adc_pkg::POS_TEMP0, touch_adc_pkg::NEG_VSS, 1'b0};
      3'h1: return f ? {touch_adc_pkg::POS_PROBE, touch_adc_pkg::NEG_BL, 1'b1}
                     : {touch_adc_pkg::POS_XP, touch_adc_pkg::NEG_YN, 1'b1};
      3'h3: return f ? 6'h00 : {touch_adc_pkg::POS_XP, touch_adc_pkg::NEG_XN, 1'b1};
      3'h4: return f ? 6'h00 : {touch_adc_pkg::POS_YN, touch_adc_pkg::NEG_XN, 1'b1};
      3'h5: return f ? {touch_adc_pkg::POS_PROBE, touch_adc_pkg::NEG_BL, 1'b1}
                     : {touch_adc_pkg::POS_YP, touch_adc_pkg::NEG_XN, 1'b1};
      3'h6: return f ? 6'h00 : {touch_adc_pkg::POS_IN, touch_adc_pkg::NEG_VSS, 1'b0};
      default: return {touch_adc_pkg::POS_TEMP1, touch_adc_pkg::NEG_VSS, 1'b0};
    endcase
  endfunction : route

  task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic setup(input logic [3:0] f);
    logic [11:0] rx;
    HOST.frame({8'ha0, f}, 12, 0, 22, rx);
    HOST.deselect();
    chk("setup_field", {8'h00, f}, {8'h00, setup_field_o});
    chk("internal_clock", {11'h000, f[0]}, {11'h000, internal_clock_o});
  endtask : setup

  task automatic convert(input logic [2:0] ch, input int lead, input int nk, input bit intl);
    logic [11:0] rx;
    logic [11:0] prev;
    logic [5:0]  r;
    logic        ok;
    prev = result_o;
    r = route(ch, panel_five_wire_i);
    ok = !panel_five_wire_i || ch inside {3'h0, 3'h1, 3'h5, 3'h7};
    HOST.frame({1'b1, ch, 8'h00}, 8, lead, nk, rx);
    if (nk == 22) begin
      chk("route_pos", {9'h000, r[5:3]}, {9'h000, analog_o.pos});
      if (ok) chk("route_ref", {9'h000, r[2:0]}, {9'h000, analog_o.neg, analog_o.differential});
      if (panel_five_wire_i && ch[1:0] == 2'h1) chk("corners", {8'h00, ch[2] ? 4'h7 : 4'he}, {8'h00, corners});
    end
    HOST.deselect();
    if (intl) repeat (400) @(posedge clk_i);
    if (ok && !intl && nk == 22) chk("dout_word", ain, rx);
    if (ok) chk("result", (nk == 22) ? ain : prev, result_o);
  endtask : convert

  task automatic stop_test();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------
  // hang guard
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      stop_test();
    end
  end

  initial begin
    logic [15:0] v, w;
    logic [2:0]  c;
    num_errors = 0;
    checks = 0;
    cycles = 0;
    rst_i = 1'b1;
    ain = 12'h000;
    panel_five_wire_i = 1'b0;
    lfsr = 16'ha00f;
    repeat (8) @(posedge clk_i);
    #1 rst_i = 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
    chk("result_reset", 12'h000, result_o);
    setup(4'ha);
    // both axes and every channel code except setup, random panel and rate
    for (int i = 0; i < 40; i++) begin
      v = lfsr_next();
      panel_five_wire_i = v[3];
      HOST.half = 6 + int'(v[6:4]);
      c = (v[2:0] == 3'h2) ? 3'h6 : v[2:0];
      // pressure only asked of four-wire panels
      if (v[3] && c inside {3'h3, 3'h4}) c = 3'h1;
      w = lfsr_next();
      ain = (i < 2) ? {12{i[0]}} : w[11:0];
      convert(c, int'(v[8:7]), 22, 1'b0);
    end
    // abort in mid conversion keeps the old result
    panel_five_wire_i = 1'b0;
    HOST.half = 8;
    ain = 12'h5a5;
    convert(3'h5, 0, 12, 1'b0);
    // oscillator-clocked conversion
    setup(4'hb);
    ain = 12'h3c7;
    convert(3'h6, 1, 22, 1'b1);
    setup(4'h4);
    stop_test();
  end
endmodule : touch_panel_adc_sequencer_tb_top
`default_nettype wire
